// ===== hdl/dcg_clock_config.v
// DSL clock generator configuration: indirect registers, pre-scaler and reference divisor
`timescale 1ns/10ps
`default_nettype none
`include "dcg_defines.vh"

module dcg_clock_config (
    input wire core_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire reference_clock_input,
    output wire generator_source_select,
    output reg prescale_pulse,
    output reg ref_div_pulse,
    input wire [4:0] rate_index,
    input wire rate_dir,
    output reg [8:0] group_factor,
    output reg [8:0] synth_factor
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] select_r;
reg [7:0] basic_r;
reg [7:0] pre_tc_r;
reg [7:0] pre_num_r;
reg [7:0] ref_div_r;
reg [7:0] grp_lsb_r [0:2*`DCG_NUM_GROUPS-1];
reg grp_msb_r [0:2*`DCG_NUM_GROUPS-1];
reg [7:0] syn_lsb_r [0:`DCG_NUM_PORTS-1];
reg syn_msb_r [0:`DCG_NUM_PORTS-1];
reg [8:0] pre_acc_r;
// Ten bits: the largest terminal count, 255 plus 257, needs them
reg [9:0] ref_cnt_r;
reg ref_s1_r;
reg ref_s2_r;
reg ref_s3_r;
reg [7:0] rdata_nxt;
integer i;

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Write strobe aimed at one register offset
function dcg_wr_hit;
    input wr;
    input [3:0] addr;
    input [3:0] target;
    begin
        dcg_wr_hit = wr && (addr == target);
    end
endfunction

// Single stored msb widened to a read byte
function [7:0] dcg_msb_byte;
    input msb;
    begin
        dcg_msb_byte = {7'h00, msb};
    end
endfunction

// Fold the accumulator back below the denominator after a pulse.
// A remainder still at or above the denominator would make it climb and
// wrap, so it is pinned to zero; a numerator at or above it pulses every tick.
function [8:0] dcg_acc_next;
    input [8:0] sum;
    input [8:0] den;
    reg [8:0] diff;
    begin
        diff = sum - den;
        if (diff >= den)
            dcg_acc_next = 9'h000;
        else
            dcg_acc_next = diff;
    end
endfunction

// ----------------------------------------
// Decode
// ----------------------------------------
wire [2:0] ctl_type = select_r[`DCG_SEL_TYPE_HI:`DCG_SEL_TYPE_LO];
wire [4:0] grp_idx = {select_r[`DCG_SEL_DIR_BIT], select_r[3:0]};
wire [4:0] port_idx = select_r[4:0];
// A new select steers data writes from the following cycle on
wire sel_wr = dcg_wr_hit(reg_wr, reg_addr, `DCG_ADDR_SEL);
wire data_wr = dcg_wr_hit(reg_wr, reg_addr, `DCG_ADDR_DATA);
wire [8:0] pre_den = {1'b0, pre_tc_r} + 9'h001;
// Terminal count kept at ten bits so a written 255 does not wrap to 0
wire [9:0] ref_tc = {2'h0, ref_div_r} + {1'b0, `DCG_REF_TC_BASE};
wire [8:0] pre_sum = pre_acc_r + {1'b0, pre_num_r};
// Factor outputs address groups as {direction, group number}
wire [4:0] rate_grp = {rate_dir, rate_index[3:0]};

// Source bit drives the clock mux select
assign generator_source_select = basic_r[`DCG_BASIC_SRC_BIT];

// Join msb and low byte into one factor
function [8:0] dcg_join;
    input msb;
    input [7:0] lsb;
    begin
        dcg_join = {msb, lsb};
    end
endfunction

// ----------------------------------------
// Register writes
// ----------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        select_r <= `DCG_RST_BYTE;
        basic_r <= `DCG_RST_BYTE;
        pre_tc_r <= `DCG_RST_PRE_TC;
        pre_num_r <= `DCG_RST_BYTE;
        ref_div_r <= `DCG_RST_BYTE;
        for (i = 0; i < 2*`DCG_NUM_GROUPS; i = i + 1)
        begin
            grp_lsb_r[i] <= `DCG_RST_BYTE;
            grp_msb_r[i] <= 1'b0;
        end
        for (i = 0; i < `DCG_NUM_PORTS; i = i + 1)
        begin
            syn_lsb_r[i] <= `DCG_RST_BYTE;
            syn_msb_r[i] <= 1'b0;
        end
    end
    else
    begin
        if (sel_wr)
            select_r <= reg_wdata;
        // Only the selected element takes the byte; msb types keep bit 0
        if (data_wr)
        begin
            case (ctl_type)
                `DCG_CT_BASIC: basic_r <= reg_wdata;
                `DCG_CT_PRE_TC: pre_tc_r <= reg_wdata;
                `DCG_CT_PRE_NUM: pre_num_r <= reg_wdata;
                `DCG_CT_REF_DIV: ref_div_r <= reg_wdata;
                `DCG_CT_GRP_LSB: grp_lsb_r[grp_idx] <= reg_wdata;
                `DCG_CT_GRP_MSB: grp_msb_r[grp_idx] <= reg_wdata[0];
                `DCG_CT_SYN_LSB: syn_lsb_r[port_idx] <= reg_wdata;
                `DCG_CT_SYN_MSB: syn_msb_r[port_idx] <= reg_wdata[0];
                default: basic_r <= basic_r;
            endcase
        end
    end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @*
begin
    rdata_nxt = 8'h00;
    case (reg_addr)
        `DCG_ADDR_SEL: rdata_nxt = select_r;
        // Data offset reads back the element that the select points at
        `DCG_ADDR_DATA:
        begin
            case (ctl_type)
                `DCG_CT_BASIC: rdata_nxt = basic_r;
                `DCG_CT_PRE_TC: rdata_nxt = pre_tc_r;
                `DCG_CT_PRE_NUM: rdata_nxt = pre_num_r;
                `DCG_CT_REF_DIV: rdata_nxt = ref_div_r;
                `DCG_CT_GRP_LSB: rdata_nxt = grp_lsb_r[grp_idx];
                `DCG_CT_GRP_MSB: rdata_nxt = dcg_msb_byte(grp_msb_r[grp_idx]);
                `DCG_CT_SYN_LSB: rdata_nxt = syn_lsb_r[port_idx];
                `DCG_CT_SYN_MSB: rdata_nxt = dcg_msb_byte(syn_msb_r[port_idx]);
                default: rdata_nxt = 8'h00;
            endcase
        end
        `DCG_ADDR_STAT: rdata_nxt = ref_cnt_r[7:0]; // Live divisor count low byte
        `DCG_ADDR_RATE: rdata_nxt = pre_acc_r[7:0]; // Live accumulator low byte
        default: rdata_nxt = 8'h00;
    endcase
end

// Read data registered one cycle after strobe
// Held at zero outside the answer cycle so no stale byte shows
always @(posedge core_clk or posedge rst)
begin
    if (rst)
        reg_rdata <= 8'h00;
    else if (reg_rd)
        reg_rdata <= rdata_nxt;
    else
        reg_rdata <= 8'h00;
end

// ----------------------------------------
// Reference clock edge detect
// ----------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        ref_s1_r <= 1'b0;
        ref_s2_r <= 1'b0;
        ref_s3_r <= 1'b0;
    end
    else
    begin
        ref_s1_r <= reference_clock_input;
        ref_s2_r <= ref_s1_r;
        ref_s3_r <= ref_s2_r;
    end
end

// Input tick: every core clock, or a reference rising edge.
// A reference tick lands two core cycles after the pin edge.
wire src_tick = generator_source_select ? (ref_s2_r & ~ref_s3_r) : 1'b1;

// ----------------------------------------
// Fractional pre-scaler
// ----------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        pre_acc_r <= 9'h000;
        prescale_pulse <= 1'b0;
    end
    else
    begin
        prescale_pulse <= 1'b0;
        if (src_tick)
        begin
            // Add numerator, subtract denominator on overflow
            if (pre_sum >= pre_den)
            begin
                pre_acc_r <= dcg_acc_next(pre_sum, pre_den);
                prescale_pulse <= 1'b1;
            end
            else
                pre_acc_r <= pre_sum;
        end
    end
end

// ----------------------------------------
// Reference divisor
// ----------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        ref_cnt_r <= 10'h000;
        ref_div_pulse <= 1'b0;
    end
    else
    begin
        ref_div_pulse <= 1'b0;
        if (src_tick)
        begin
            // Wrap after the terminal count: period is the count plus one
            if (ref_cnt_r >= ref_tc)
            begin
                ref_cnt_r <= 10'h000;
                ref_div_pulse <= 1'b1;
            end
            else
                ref_cnt_r <= ref_cnt_r + 10'h001;
        end
    end
end

// ----------------------------------------
// Bandwidth factor outputs
// ----------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        group_factor <= 9'h000;
        synth_factor <= 9'h000;
    end
    else
    begin
        group_factor <= dcg_join(grp_msb_r[rate_grp], grp_lsb_r[rate_grp]);
        synth_factor <= dcg_join(syn_msb_r[rate_index], syn_lsb_r[rate_index]);
    end
end

endmodule // dcg_clock_config
`default_nettype wire

// ===== hdl/dcg_defines.vh
// Constants for the DSL clock generator configuration block
`ifndef DCG_DEFINES_VH
`define DCG_DEFINES_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DCG_ADDR_SEL 4'h0
`define DCG_ADDR_DATA 4'h4
`define DCG_ADDR_STAT 4'h8
`define DCG_ADDR_RATE 4'hC
// ----------------------------------------
// Select register fields
// ----------------------------------------
`define DCG_SEL_TYPE_HI 7
`define DCG_SEL_TYPE_LO 5
`define DCG_SEL_DIR_BIT 4
// ----------------------------------------
// Control types
// ----------------------------------------
`define DCG_CT_BASIC 3'h0
`define DCG_CT_PRE_TC 3'h1
`define DCG_CT_PRE_NUM 3'h2
`define DCG_CT_REF_DIV 3'h3
`define DCG_CT_GRP_LSB 3'h4
`define DCG_CT_GRP_MSB 3'h5
`define DCG_CT_SYN_LSB 3'h6
`define DCG_CT_SYN_MSB 3'h7
// ----------------------------------------
// Basic setup bits, reset values and reference divisor base
// ----------------------------------------
`define DCG_BASIC_SRC_BIT 4
`define DCG_RST_BYTE 8'h00
`define DCG_RST_PRE_TC 8'h00
`define DCG_REF_TC_BASE 9'h101
// ----------------------------------------
// Element counts
// ----------------------------------------
`define DCG_NUM_GROUPS 16
`define DCG_NUM_PORTS 32
`endif

// ===== testbench/dcg_clock_config_chk.sv
// Checker for the clock generator configuration block
`timescale 1ns/10ps
`default_nettype none
module dcg_clock_config_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic generator_source_select,
    input wire logic prescale_pulse,
    input wire logic ref_div_pulse,
    input wire logic [4:0] rate_index,
    input wire logic rate_dir,
    input wire logic [8:0] group_factor,
    input wire logic [8:0] synth_factor
);
// ----------------------------------------
// Decoded accesses
// ----------------------------------------
wire logic w_sel = reg_wr && reg_addr == 4'h0;
wire logic w_dat = reg_wr && reg_addr == 4'h4;
wire logic r_dat = reg_rd && reg_addr == 4'h4;
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
// Read data port, indirect pair, divisor pulse spacing and factor hold
rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
unmapped_rd_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
sel_back_a: assert property (w_sel ##1 reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("select readback wrong");
byte_back_a: assert property (w_sel && reg_wdata[7:5] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}
    ##1 w_dat ##1 r_dat |=> reg_rdata == $past(reg_wdata, 2))
    else $error("data byte readback wrong");
msb_back_a: assert property (w_sel && reg_wdata[7:5] inside {3'h5, 3'h7}
    ##1 w_dat ##1 r_dat |=> reg_rdata == {7'h00, $past(reg_wdata[0], 2)})
    else $error("msb readback wrong");
src_sel_a: assert property (w_sel && reg_wdata[7:5] == 3'h0 ##1 w_dat
    |=> generator_source_select == $past(reg_wdata[4]))
    else $error("source select wrong");
ref_gap_a: assert property (ref_div_pulse |=> !ref_div_pulse [*8])
    else $error("divisor pulses too close");
fac_hold_a: assert property (!reg_wr && $stable({rate_index, rate_dir}) ##1 !reg_wr
    && $stable({rate_index, rate_dir}) |=> $stable({group_factor, synth_factor}))
    else $error("factor moved without cause");
cover property (ref_div_pulse);
cover property (prescale_pulse);
cover property (r_dat);
endmodule // dcg_clock_config_chk
bind dcg_clock_config dcg_clock_config_chk u_chk (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .generator_source_select(generator_source_select),
    .prescale_pulse(prescale_pulse),
    .ref_div_pulse(ref_div_pulse),
    .rate_index(rate_index),
    .rate_dir(rate_dir),
    .group_factor(group_factor),
    .synth_factor(synth_factor)
);
`default_nettype wire

// ===== testbench/tb_dcg_clock_config.sv
// Testbench for the clock generator configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_dcg_clock_config;
// ----------------------------------------
// Stimulus, checks and scenarios
// ----------------------------------------
logic core_clk, rst, reg_wr, reg_rd, ref_in, rate_dir, gss, pre_p, ref_p;
logic [3:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata;
logic [4:0] rate_index;
logic [8:0] g_f, s_f;
int n_fail = 0;
int n_compared = 0;
dcg_clock_config u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reference_clock_input(ref_in), .generator_source_select(gss),
    .prescale_pulse(pre_p), .ref_div_pulse(ref_p), .rate_index(rate_index),
    .rate_dir(rate_dir), .group_factor(g_f), .synth_factor(s_f));
task automatic close_out;
    if (n_fail == 0 && n_compared > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input string nm, input logic [9:0] s, e);
    n_compared++;
    if (s !== e)
    begin
        n_fail++;
        $display("FAIL %s exp %h seen %h", nm, e, s);
    end
endtask
task automatic wsel(input logic [7:0] s);
    reg_addr <= 4'h0;
    reg_wdata <= s;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge core_clk);
endtask
task automatic cfg(input logic [7:0] s, d);
    wsel(s);
    reg_addr <= 4'h4;
    reg_wdata <= d;
    @(posedge core_clk);
endtask
task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
endtask
task automatic t_reset;
    logic [7:0] d;
    logic [7:0] sl [4] = '{8'h40, 8'h80, 8'hC0, 8'hE0};
    for (int i = 0; i < 4; i++)
    begin
        wsel(sl[i]);
        rd(4'h0, d);
        chk("sel_back", {2'b0, d}, {2'b0, sl[i]});
        rd(4'h4, d);
        chk("reset_byte", {2'b0, d}, 10'h000);
    end
    rd(4'h2, d);
    chk("unmapped", {2'b0, d}, 10'h000);
endtask
task automatic t_bytes;
    logic [7:0] d;
    logic [2:0] ty [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    for (int i = 0; i < 5; i++)
    begin
        cfg({ty[i], 5'h00}, 8'h35 + 8'(i));
        rd(4'h4, d);
        chk("data_back", {2'b0, d}, {2'b0, 8'h35 + 8'(i)});
    end
endtask
task automatic t_rate(input logic d, input logic [4:0] i, input logic [8:0] g, s);
    reg_wr <= 1'b0;
    rate_dir <= d;
    rate_index <= i;
    repeat (2) @(posedge core_clk);
    #1;
    chk("grp_factor", {1'b0, g_f}, {1'b0, g});
    chk("syn_factor", {1'b0, s_f}, {1'b0, s});
    @(posedge core_clk);
endtask
task automatic t_factor;
    logic [7:0] d;
    cfg(8'hA0, 8'hFF);
    rd(4'h4, d);
    chk("grp_msb_back", {2'b0, d}, 10'h001);
    cfg(8'hE0, 8'hFF);
    rd(4'h4, d);
    chk("syn_msb_back", {2'b0, d}, 10'h001);
    cfg(8'h93, 8'hAB);
    t_rate(1'b0, 5'h00, 9'h138, 9'h139);
    t_rate(1'b1, 5'h03, 9'h0AB, 9'h000);
    t_rate(1'b0, 5'h03, 9'h000, 9'h000);
endtask
task automatic t_pre(input logic [7:0] num, input int e);
    int n;
    logic [7:0] d;
    cfg(8'h40, num);
    reg_wr <= 1'b0;
    repeat (8) @(posedge core_clk);
    n = 0;
    repeat (40)
    begin
        @(posedge core_clk);
        #1 n += int'(pre_p === 1'b1);
    end
    chk("pre_pulses", 10'(n), 10'(e));
    // With a unit numerator the accumulator restarts at zero on a pulse
    if (num == 8'h01)
    begin
        for (int k = 0; k < 8 && pre_p !== 1'b1; k++)
        begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        rd(4'hC, d);
        chk("acc_step", {2'b0, d}, {2'b0, num});
    end
endtask
task automatic t_ref(input logic [7:0] v, input logic s, input int p);
    int n;
    logic [7:0] d;
    cfg(8'h00, {3'h0, s, 4'h0});
    cfg(8'h60, v);
    reg_wr <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1 n++;
        end
        while (ref_p !== 1'b1 && n < 1200);
    end
    // Count restarts at zero on the wrap and steps once per tick after it
    @(posedge core_clk);
    rd(4'h8, d);
    chk("div_count", {2'b0, d}, {9'h000, !s});
    chk("src_sel", {9'h000, gss}, {9'h000, s});
    chk("ref_period", 10'(n), 10'(p));
endtask
// Clock, reference input toggling every cycle, watchdog
initial
begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
end
always @(posedge core_clk) ref_in <= ~ref_in;
initial
begin
    #5000000;
    n_fail++;
    close_out;
end
// Main sequence
initial
begin
    {rst, reg_wr, reg_rd, ref_in, rate_dir} = 5'h10;
    {reg_addr, reg_wdata, rate_index} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_bytes;
    t_factor;
    cfg(8'h20, 8'h03);
    t_pre(8'h01, 10);
    t_pre(8'h03, 30);
    t_pre(8'h00, 0);
    t_ref(8'h00, 1'b0, 258);
    t_ref(8'h02, 1'b0, 260);
    t_ref(8'h00, 1'b1, 516);
    close_out;
end
endmodule // tb_dcg_clock_config
`default_nettype wire
